// ### rtl/cwm_deadband.sv
// Edge delay unit: delays the rising edge of its input by a count
`timescale 1ns/10ps
module cwm_deadband #(
  parameter int DB_W = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic sig_in,
  input wire logic [DB_W-1:0] delay,
  output logic sig_out
);
  logic [DB_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  // Count from zero up to delay while input high; drop at once when low
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!run || !sig_in) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (!out_q) begin
      if (cnt_q == delay) begin
        out_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Zero count gives a one-clock registered path only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign sig_out = out_q;
endmodule

// ### rtl/cwm_pkg.sv
// Package: register map, field layout and constants for the waveform unit
package cwm_pkg;
  // Register byte offsets (AXI4-Lite word aligned)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] POL_OFS = 8'h04;
  localparam logic [7:0] STEER_OFS = 8'h08;
  localparam logic [7:0] DBR_OFS = 8'h0C;
  localparam logic [7:0] DBF_OFS = 8'h10;
  localparam logic [7:0] SRC_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  // Control field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHDN_BIT = 6;
  // Steering register: enables in [3:0], fixed levels in [7:4]
  localparam int STEER_LVL_LSB = 4;
  // Field widths
  localparam int MODE_W = 3;
  localparam int DB_W = 6;
  localparam int SRC_W = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [7:0] STEER_RST = 8'h00;
  localparam logic [5:0] DB_RST = 6'h00;
  localparam logic [3:0] SRC_RST = 4'h0;
  // Mode codes
  localparam logic [2:0] MODE_ASTEER = 3'h0;
  localparam logic [2:0] MODE_SSTEER = 3'h1;
  localparam logic [2:0] MODE_FWD = 3'h2;
  localparam logic [2:0] MODE_REV = 3'h3;
  localparam logic [2:0] MODE_HALF = 3'h4;
  localparam logic [2:0] MODE_PP = 3'h5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/cwm_top.sv
// Complementary waveform unit: mode steering, dead band, AXI4-Lite regs
`timescale 1ns/10ps
module cwm_top #(
  parameter int SRC_N = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [SRC_N-1:0] src_in,
  input wire logic shutdown_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic out_a,
  output logic out_b,
  output logic out_c,
  output logic out_d
);
  typedef enum logic [1:0] {
    PP_A = 2'b01,
    PP_B = 2'b10
  } cwm_pp_t;

  // Register state
  logic [7:0] ctrl_q, ctrl_d;
  logic [3:0] pol_q, pol_d;
  logic [7:0] steer_q, steer_d;
  logic [5:0] dbr_q, dbr_d;
  logic [5:0] dbf_q, dbf_d;
  logic [3:0] src_q, src_d;
  // Bus state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic awready_q, wready_q, arready_q;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Datapath state
  logic [2:0] in_sync_q, sh_sync_q;
  logic in_prev_q, sh_prev_q;
  logic [3:0] str_act_q, str_act_d;
  logic [2:0] mode_act_q, mode_act_d;
  cwm_pp_t pp_q, pp_d;
  logic pp_pulse_q, pp_pulse_d;
  logic [3:0] outs_q, outs_d;
  logic dir_db_q, dir_db_d;

  logic enable, shdn, pin, in_rise, in_fall, do_wr, wr_ctrl, wr_steer;
  logic rise_dly, fall_dly, dir_dly, bridge_swap;
  logic [2:0] mode_reg;
  logic [3:0] raw;

  assign enable = ctrl_q[cwm_pkg::CTRL_EN_BIT];
  assign mode_reg = ctrl_q[cwm_pkg::CTRL_MODE_LSB +: cwm_pkg::MODE_W];
  // Input is agreed once second and third stages match
  assign pin = (in_sync_q[2] == in_sync_q[1]) ? in_sync_q[2] : in_prev_q;
  assign shdn = (sh_sync_q[2] == sh_sync_q[1]) ? sh_sync_q[2] : sh_prev_q;
  assign in_rise = pin & ~in_prev_q;
  assign in_fall = ~pin & in_prev_q;

  // Byte-lane merge shared by all register writes
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    merge8 = st[0] ? wd[7:0] : old;
  endfunction
  // True for the two full-bridge directions
  function automatic logic is_bridge(input logic [2:0] m);
    is_bridge = m == cwm_pkg::MODE_FWD || m == cwm_pkg::MODE_REV;
  endfunction
  assign bridge_swap = mode_reg != mode_act_q && is_bridge(mode_reg) &&
                       is_bridge(mode_act_q);

  // Write address and data taken in any order, response after both
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q && !bvalid_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q > cwm_pkg::SRC_OFS || awaddr_q[1:0] != 2'h0) ?
                cwm_pkg::RESP_SLVERR : cwm_pkg::RESP_OKAY;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end
  assign do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_ctrl = do_wr && awaddr_q == cwm_pkg::CTRL_OFS;
  assign wr_steer = do_wr && awaddr_q == cwm_pkg::STEER_OFS;

  // Register writes
  always_comb begin
    ctrl_d = ctrl_q;
    pol_d = pol_q;
    steer_d = steer_q;
    dbr_d = dbr_q;
    dbf_d = dbf_q;
    src_d = src_q;
    if (wr_ctrl) begin
      ctrl_d = merge8(ctrl_q, wdata_q, wstrb_q) & 8'h87;
    end
    if (do_wr && awaddr_q == cwm_pkg::POL_OFS) begin
      pol_d = 4'(merge8({4'h0, pol_q}, wdata_q, wstrb_q));
    end
    if (wr_steer) begin
      steer_d = merge8(steer_q, wdata_q, wstrb_q);
    end
    if (do_wr && awaddr_q == cwm_pkg::DBR_OFS) begin
      dbr_d = 6'(merge8({2'h0, dbr_q}, wdata_q, wstrb_q));
    end
    if (do_wr && awaddr_q == cwm_pkg::DBF_OFS) begin
      dbf_d = 6'(merge8({2'h0, dbf_q}, wdata_q, wstrb_q));
    end
    if (do_wr && awaddr_q == cwm_pkg::SRC_OFS) begin
      src_d = 4'(merge8({4'h0, src_q}, wdata_q, wstrb_q));
    end
  end

  // Read channel; status shows live outputs, active mode, active steering and push-pull phase
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = cwm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cwm_pkg::CTRL_OFS: rdata_d = {24'h0, ctrl_q[7], shdn, 3'h0,
                                      ctrl_q[2:0]};
        cwm_pkg::POL_OFS: rdata_d = {28'h0, pol_q};
        cwm_pkg::STEER_OFS: rdata_d = {24'h0, steer_q};
        cwm_pkg::DBR_OFS: rdata_d = {26'h0, dbr_q};
        cwm_pkg::DBF_OFS: rdata_d = {26'h0, dbf_q};
        cwm_pkg::SRC_OFS: rdata_d = {28'h0, src_q};
        cwm_pkg::STAT_OFS: rdata_d = {20'h0, mode_act_q, str_act_q,
                                      pp_q == PP_B, outs_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = cwm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Steering, direction and push-pull sequencing
  always_comb begin
    str_act_d = str_act_q;
    mode_act_d = mode_act_q;
    pp_d = pp_q;
    pp_pulse_d = pp_pulse_q;
    dir_db_d = dir_db_q;
    if (!enable) begin
      mode_act_d = mode_reg;
      str_act_d = steer_q[3:0];
      pp_d = PP_A;
      pp_pulse_d = 1'b0;
      dir_db_d = 1'b0;
    end else begin
      if (mode_reg == cwm_pkg::MODE_ASTEER) begin
        str_act_d = steer_q[3:0];
      end else if (in_rise) begin
        str_act_d = steer_q[3:0];
      end
      if (mode_reg != mode_act_q && !bridge_swap) begin
        mode_act_d = mode_reg;
      end else if (bridge_swap && in_rise) begin
        mode_act_d = mode_reg;
        dir_db_d = 1'b1;
      end else if (in_fall) begin
        dir_db_d = 1'b0;
      end
      if (shdn) begin
        pp_d = PP_A;
        pp_pulse_d = 1'b0;
      end else if (in_rise) begin
        pp_pulse_d = 1'b1;
      end else if (in_fall && pp_pulse_q) begin
        pp_d = (pp_q == PP_A) ? PP_B : PP_A;
        pp_pulse_d = 1'b0;
      end
    end
  end

  // Mode decode into active-high drives, before polarity
  always_comb begin
    raw = 4'h0;
    unique case (mode_act_q)
      cwm_pkg::MODE_HALF: begin
        raw = {fall_dly, rise_dly, fall_dly, rise_dly};
      end
      cwm_pkg::MODE_PP: begin
        raw[0] = pp_pulse_q && pp_q == PP_A && pin;
        raw[1] = pp_pulse_q && pp_q == PP_B && pin;
        raw[2] = raw[0];
        raw[3] = raw[1];
      end
      cwm_pkg::MODE_FWD: begin
        raw = {dir_db_q ? dir_dly : pin, 3'b001};
      end
      cwm_pkg::MODE_REV: begin
        raw = {2'b01, dir_db_q ? dir_dly : pin, 1'b0};
      end
      default: begin
        raw = {4{pin}};
      end
    endcase
  end

  // Polarity, steering levels and shutdown applied at the pins
  always_comb begin
    outs_d = pol_q;
    if (enable && !shdn) begin
      for (int i = 0; i < 4; i++) begin
        if (mode_act_q == cwm_pkg::MODE_ASTEER ||
            mode_act_q == cwm_pkg::MODE_SSTEER) begin
          outs_d[i] = str_act_q[i] ? (pin ^ pol_q[i])
                    : steer_q[cwm_pkg::STEER_LVL_LSB + i];
        end else begin
          outs_d[i] = raw[i] ^ pol_q[i];
        end
      end
    end
  end

  // Rising and falling dead bands, plus direction-change band
  cwm_deadband #(.DB_W(cwm_pkg::DB_W)) u_rise (
    .clock(clock), .rst_n(rst_n), .run(enable), .sig_in(pin),
    .delay(dbr_q), .sig_out(rise_dly));
  cwm_deadband #(.DB_W(cwm_pkg::DB_W)) u_fall (
    .clock(clock), .rst_n(rst_n), .run(enable), .sig_in(~pin),
    .delay(dbf_q), .sig_out(fall_dly));
  cwm_deadband #(.DB_W(cwm_pkg::DB_W)) u_dir (
    .clock(clock), .rst_n(rst_n), .run(dir_db_q), .sig_in(pin),
    .delay(mode_act_q == cwm_pkg::MODE_REV ? dbr_q : dbf_q),
    .sig_out(dir_dly));

  // All state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= cwm_pkg::CTRL_RST;
      steer_q <= cwm_pkg::STEER_RST;
      {pol_q, src_q} <= {cwm_pkg::POL_RST, cwm_pkg::SRC_RST};
      {dbr_q, dbf_q} <= {cwm_pkg::DB_RST, cwm_pkg::DB_RST};
      {aw_hold_q, w_hold_q, awaddr_q, wdata_q, wstrb_q} <= '0;
      {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q} <= '0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      {in_sync_q, sh_sync_q, in_prev_q, sh_prev_q} <= '0;
      {str_act_q, mode_act_q, pp_pulse_q, outs_q, dir_db_q} <= '0;
      pp_q <= PP_A;
    end else begin
      {ctrl_q, pol_q, steer_q} <= {ctrl_d, pol_d, steer_d};
      {dbr_q, dbf_q, src_q} <= {dbr_d, dbf_d, src_d};
      {aw_hold_q, w_hold_q, awaddr_q} <= {aw_hold_d, w_hold_d, awaddr_d};
      {wdata_q, wstrb_q} <= {wdata_d, wstrb_d};
      {bvalid_q, bresp_q} <= {bvalid_d, bresp_d};
      {rvalid_q, rdata_q, rresp_q} <= {rvalid_d, rdata_d, rresp_d};
      awready_q <= ~aw_hold_d & ~bvalid_d; // Registered from next state
      wready_q <= ~w_hold_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      in_sync_q <= {in_sync_q[1:0], src_in[src_q]};
      sh_sync_q <= {sh_sync_q[1:0], shutdown_in};
      in_prev_q <= pin;
      sh_prev_q <= shdn;
      {str_act_q, mode_act_q} <= {str_act_d, mode_act_d};
      pp_q <= pp_d;
      {pp_pulse_q, outs_q, dir_db_q} <= {pp_pulse_d, outs_d, dir_db_d};
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign out_a = outs_q[0];
  assign out_b = outs_q[1];
  assign out_c = outs_q[2];
  assign out_d = outs_q[3];
endmodule

// ### verif/cwm_switch_load.sv
// Far-side model: switch drivers counting turn-on edges of A and B
`timescale 1ns/10ps
module cwm_switch_load (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic drv_a,
  input wire logic drv_b,
  output logic [7:0] on_a,
  output logic [7:0] on_b
);
  logic a_q, b_q;
  // Drivers see only levels; a glitch of one clock still counts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      {a_q, b_q, on_a, on_b} <= '0;
    else begin
      a_q <= drv_a;
      b_q <= drv_b;
      on_a <= on_a + {7'h00, drv_a & ~a_q};
      on_b <= on_b + {7'h00, drv_b & ~b_q};
    end
  end
endmodule

// ### verif/cwm_top_asserts.sv
// Checker: output-stage relations watched from the top-level ports
`timescale 1ns/10ps
module cwm_top_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shutdown_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_c,
  input wire logic out_d
);
  logic [7:0] aw_q, aw_d, wd_q, wd_d, ctl_q, ctl_d, str_q, str_d;
  logic [3:0] pol_q, pol_d, o, act;
  logic [5:0] age_q, age_d, sd_q;
  logic bv_q, en, rdy;
  logic [2:0] md;
  // Active view of the outputs: 1 means driven to its active level
  assign o = {out_d, out_c, out_b, out_a};
  assign act = o ^ pol_q;
  assign en = ctl_q[7];
  assign md = ctl_q[2:0];
  assign rdy = age_q > 6'h03 && sd_q == 6'h00; // Settled after register writes and shutdown
  // Register mirror; taken when the OKAY response first shows, which
  // is one clock after the edge the design itself updates its registers
  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    ctl_d = ctl_q;
    pol_d = pol_q;
    str_d = str_q;
    age_d = (age_q == 6'h3F) ? age_q : age_q + 6'h01;
    if (s_axi_awvalid && s_axi_awready)
      aw_d = s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      wd_d = s_axi_wdata[7:0];
    if (s_axi_bvalid && !bv_q && s_axi_bresp == cwm_pkg::RESP_OKAY) begin
      age_d = 6'h00;
      if (aw_q == cwm_pkg::CTRL_OFS)
        ctl_d = wd_q;
      if (aw_q == cwm_pkg::POL_OFS)
        pol_d = wd_q[3:0];
      if (aw_q == cwm_pkg::STEER_OFS)
        str_d = wd_q;
    end
  end
  // Mirror registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      {aw_q, wd_q, ctl_q, str_q, pol_q, age_q, bv_q, sd_q} <= '0;
    else
      {aw_q, wd_q, ctl_q, str_q, pol_q, age_q, bv_q, sd_q} <=
        {aw_d, wd_d, ctl_d, str_d, pol_d, age_d, s_axi_bvalid,
         sd_q[4:0], shutdown_in};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_IDLE_LEVELS:
    assert property (rdy && !en |-> o == pol_q)
    else $error("outputs not idle while disabled");
  AST_HALF_GAP:
    assert property (rdy && en && md == cwm_pkg::MODE_HALF
      |-> !(act[0] && act[1])) else $error("half bridge overlap");
  AST_HALF_CD:
    assert property (rdy && en && md == cwm_pkg::MODE_HALF
      |-> act[2] == act[0] && act[3] == act[1])
    else $error("half bridge C or D differ");
  AST_PP_SPLIT:
    assert property (rdy && en && md == cwm_pkg::MODE_PP && $rose(act[1])
      |-> !act[0]) else $error("push-pull both active");
  AST_PP_CD:
    assert property (rdy && en && md == cwm_pkg::MODE_PP
      |-> act[2] == act[0] && act[3] == act[1])
    else $error("push-pull C or D differ");
  AST_STEER_FIX:
    assert property (rdy && en && md == cwm_pkg::MODE_ASTEER && !str_q[1]
      |-> out_b == str_q[5]) else $error("fixed steer level wrong");
  AST_FWD_STATIC:
    assert property (rdy && en && md == cwm_pkg::MODE_FWD
      |-> act[0] && !act[1] && !act[2]) else $error("forward statics");
  AST_REV_STATIC:
    assert property (age_q == 6'h3F && en && md == cwm_pkg::MODE_REV
      |-> act[2] && !act[0] && !act[3]) else $error("reverse statics");
  AST_SHDN_IDLE:
    assert property (shutdown_in [*6] |-> o == pol_q)
    else $error("outputs active during shutdown");
endmodule

// ### verif/test_cwm_top.sv
// Testbench: bus access and output-mode scenarios for the waveform unit
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module test_cwm_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] src_in = 16'h0000;
  logic shutdown_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, out_a, out_b, out_c, out_d, ga, gw, dn;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [7:0] on_a, on_b, a0, b0;
  int failures = 0;
  int tests_run = 0;
  int c0, c1;
  always #10 clock = ~clock;
  cwm_top dut (.clock, .rst_n, .src_in, .shutdown_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .out_a, .out_b, .out_c, .out_d);
  cwm_switch_load load (.clock, .rst_n, .drv_a(out_a), .drv_b(out_b),
    .on_a, .on_b);
  task automatic final_report;
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    failures++;
    final_report();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One write; each channel dropped after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    dn = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn && n < 50) begin
      @(negedge clock);
      ga = s_axi_awvalid & s_axi_awready;
      gw = s_axi_wvalid & s_axi_wready;
      dn = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (ga)
        s_axi_awvalid <= 1'b0;
      if (gw)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!dn)
      hang();
  endtask
  task automatic ctl(input logic [7:0] v);
    wr(cwm_pkg::CTRL_OFS, {24'h000000, v});
  endtask
  // One read, compared against data and response code
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r);
    int n;
    n = 0;
    dn = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn && n < 50) begin
      @(negedge clock);
      ga = s_axi_arvalid & s_axi_arready;
      dn = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ga)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!dn)
      hang();
    `CHK(rdat, e)
    `CHK(resp, r)
  endtask
  task automatic pin(input logic v);
    @(posedge clock);
    src_in[0] <= v;
  endtask
  task automatic pulse;
    pin(1'b1);
    cyc(8);
    pin(1'b0);
    cyc(8);
  endtask
  task automatic chk_o(input logic [3:0] e);
    @(negedge clock);
    `CHK({out_d, out_c, out_b, out_a}, e)
  endtask
  // Counts negedges until output i reaches v; bounded
  task automatic wait_o(input int i, input logic v, output int c);
    logic [3:0] o;
    c = 0;
    do begin
      @(negedge clock);
      c++;
      o = {out_d, out_c, out_b, out_a};
    end while (o[i] !== v && c < 100);
    if (o[i] !== v)
      hang();
  endtask
  task automatic t_regs;
    rd_chk(cwm_pkg::CTRL_OFS, 32'h00000000, cwm_pkg::RESP_OKAY);
    rd_chk(8'h40, 32'h00000000, cwm_pkg::RESP_SLVERR);
    wr(8'h40, 32'h000000FF);
    `CHK(resp, cwm_pkg::RESP_SLVERR)
    wr(cwm_pkg::POL_OFS, 32'h00000005);
    rd_chk(cwm_pkg::POL_OFS, 32'h00000005, cwm_pkg::RESP_OKAY);
    chk_o(4'h5);
  endtask
  // Half bridge with C inverted, then a rising dead band of five
  task automatic t_half;
    wr(cwm_pkg::POL_OFS, 32'h00000004);
    ctl(8'h84);
    cyc(8);
    chk_o(4'hE);
    pin(1'b1);
    wait_o(0, 1'b1, c0);
    cyc(4);
    chk_o(4'h1);
    pin(1'b0);
    cyc(8);
    ctl(8'h00);
    wr(cwm_pkg::DBR_OFS, 32'h00000005);
    ctl(8'h84);
    cyc(8);
    pin(1'b1);
    wait_o(0, 1'b1, c1);
    `CHK(c1 - c0, 5)
    pin(1'b0);
    cyc(8);
    ctl(8'h00);
    wr(cwm_pkg::POL_OFS, 32'h00000000);
  endtask
  // Push-pull order A, B, A; re-enable restarts on A
  task automatic t_pp;
    a0 = on_a;
    b0 = on_b;
    ctl(8'h85);
    repeat (3) pulse();
    `CHK(on_a - a0, 8'h02)
    `CHK(on_b - b0, 8'h01)
    ctl(8'h00);
    ctl(8'h85);
    pulse();
    `CHK(on_a - a0, 8'h03)
    ctl(8'h00);
  endtask
  // Steering: A steered active-low, others fixed, async then sync
  task automatic t_steer;
    wr(cwm_pkg::POL_OFS, 32'h0000000F);
    wr(cwm_pkg::STEER_OFS, 32'h000000A1);
    ctl(8'h80);
    chk_o(4'hB);
    pin(1'b1);
    cyc(8);
    chk_o(4'hA);
    wr(cwm_pkg::STEER_OFS, 32'h000000B0);
    cyc(1);
    chk_o(4'hB);
    ctl(8'h00);
    ctl(8'h81);
    wr(cwm_pkg::STEER_OFS, 32'h000000B1);
    cyc(6);
    chk_o(4'hB);
    pin(1'b0);
    cyc(8);
    chk_o(4'hB);
    pin(1'b1);
    cyc(8);
    chk_o(4'hA);
    ctl(8'h00);
    pin(1'b0);
    wr(cwm_pkg::STEER_OFS, 32'h00000000);
    wr(cwm_pkg::POL_OFS, 32'h00000000);
  endtask
  // Full bridge forward, then reversed while still enabled
  task automatic t_bridge;
    ctl(8'h82);
    cyc(8);
    chk_o(4'h1);
    pin(1'b1);
    cyc(8);
    chk_o(4'h9);
    pin(1'b0);
    cyc(8);
    ctl(8'h83);
    cyc(8);
    chk_o(4'h1);
    pin(1'b1);
    cyc(20);
    chk_o(4'h6);
    pin(1'b0);
    cyc(64);
    chk_o(4'h4);
    ctl(8'h00);
  endtask
  task automatic t_shdn;
    ctl(8'h84);
    cyc(8);
    chk_o(4'hA);
    @(posedge clock);
    shutdown_in <= 1'b1;
    cyc(10);
    chk_o(4'h0);
    @(posedge clock);
    shutdown_in <= 1'b0;
    ctl(8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_half();
    t_pp();
    t_steer();
    t_bridge();
    t_shdn();
    final_report();
  end
endmodule
bind cwm_top cwm_top_asserts chk (.clock, .rst_n, .shutdown_in,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .out_a, .out_b, .out_c, .out_d);
